// >>> rtl/asr_pkg.sv
/*
  Shared constants for the serial register-access front end: register map,
  field positions, reset values, command layout and host timing.
  Assumes both ends and the bench reference these by package::name.
*/
package asr_pkg;
  // Register indices (6-bit register address space)
  localparam logic [5:0] ADDR_CMD   = 6'h00;
  localparam logic [5:0] ADDR_CTRL  = 6'h01;
  localparam logic [5:0] ADDR_IO    = 6'h03;
  localparam logic [5:0] ADDR_ID    = 6'h05;
  localparam logic [5:0] ADDR_ERR   = 6'h06;
  localparam logic [5:0] ADDR_ERREN = 6'h07;
  localparam logic [5:0] ADDR_CH0   = 6'h09;
  localparam logic [5:0] ADDR_CFG0  = 6'h19;
  localparam logic [5:0] ADDR_FLT0  = 6'h21;
  localparam int         NUM_CH     = 16;
  localparam int         NUM_SETUP  = 8;

  // Command byte layout
  localparam int CMD_EN_BIT = 7;
  localparam int CMD_RD_BIT = 6;

  // Control register fields
  localparam int         CTRL_CLK_LSB = 0;
  localparam int         CTRL_MODE_LSB = 2;
  localparam int         CTRL_PWR_LSB = 6;
  localparam logic [1:0] CLK_INT     = 2'h0;
  localparam logic [1:0] CLK_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_EXT     = 2'h2;

  // Digital output fields, error flags and enables
  localparam int IO_GPIO_LSB   = 0;
  localparam int IO_GPOE_LSB   = 2;
  localparam int ERR_IGN_BIT   = 6;
  localparam int ERREN_IGN_BIT = 6;
  localparam int ERREN_CRC_BIT = 18;

  // Reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [23:0] IO_RST    = 24'h000000;
  localparam logic [23:0] ERREN_RST = 24'h000040;
  localparam logic [15:0] CH0_RST   = 16'h8001;
  localparam logic [15:0] CH_RST    = 16'h0001;
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [23:0] FLT_RST   = 24'h000000;

  // Identity nibbles: values are arbitrary
  localparam logic [3:0] PART_CODE = 4'h3;
  localparam logic [3:0] DIE_REV   = 4'h1;

  // Serial framing
  localparam logic [6:0] RESET_ONES = 7'h40;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [5:0] CRC_BITS   = 6'h08;
  localparam logic [5:0] CMD_BITS   = 6'h08;

  // Host timing in clk_sys cycles
  localparam int HOST_HALF = 2;
  localparam int HOST_GAP  = 2;

  // Data-phase length of each register in bits
  function automatic logic [5:0] reg_bits(input logic [5:0] a);
    logic [5:0] b;
    b = 6'h08;
    if (a == ADDR_CTRL || (a >= ADDR_CH0 && a < ADDR_FLT0)) begin
      b = 6'h10;
    end
    if (a == ADDR_IO || a == ADDR_ERR || a == ADDR_ERREN || (a >= ADDR_FLT0 && a < 6'h29)) begin
      b = 6'h18;
    end
    return b;
  endfunction

  // One serial step of the checksum
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic d);
    return {c[6:0], 1'b0} ^ ((c[7] ^ d) ? CRC_POLY : 8'h00);
  endfunction
endpackage

// >>> rtl/asr_spi_if.sv
/*
  Serial link between the host end and the device end.
  Assumes one host and one device; the serial output line rests high
  whenever the device does not drive it.
*/
`timescale 1ns/1ps
interface asr_spi_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  logic misoLine;

  // Resolved level of the shared output line, pulled high when undriven
  assign misoLine = misoOe ? miso : 1'b1;

  modport dev (input sclk, input csN, input mosi, output miso, output misoOe);
  modport host (output sclk, output csN, output mosi, input misoLine);
endinterface

// >>> rtl/asr_device.sv
/*
  Device end: serial command decoder and register map, clocked by the link
  clock, plus a clk_sys side that exposes a few configuration levels.
  Assumes a mode 3 host on the link and chip select either driven or tied low.
*/
// Operation
// - Serial port works only in mode three
// - Clock rests high; launch falling, capture rising
// - Works with chip select tied or driven
// - Write-only 8-bit command register, address zero
// - After reset, next eight bits are command
// - Host always starts with a command byte
// - Bit7 enable, bit6 direction, bits5-0 address
// - After data phase, await next command
// - Write data is 8, 16 or 24 bits
// - Sixty-four ones on data input reset everything
// - Chip select high aborts, keeps registers
// - Read-only identity register at address five
// - Host should read identity after power-up
// - Reset enables channel zero, inputs zero/one, setup zero
// - Reset setup: unbuffered, gain one, external reference
// - Reset: low power, continuous, internal oscillator
// - Reset enables only the ignored-access check
// - Internal or external clock, optional clock output
// - Eight setups; each channel picks one
// - Two register-driven general-purpose outputs
`timescale 1ns/1ps
module asr_device (
  // System side
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Link
  asr_spi_if.dev          spi,
  // User side
  input  wire logic       convBusy,
  output logic [1:0]      gpioOut,
  output logic [1:0]      gpioOe,
  output logic            intClkOut,
  output logic            extClkSel
);
  typedef enum logic [2:0] {
    SER_CMD = 3'b001,
    SER_WR  = 3'b010,
    SER_RD  = 3'b100
  } asr_ser_t;

  typedef struct packed {
    logic [15:0]                       ctrl;
    logic [23:0]                       io;
    logic [23:0]                       errEn;
    logic                              ignErr;
    logic [asr_pkg::NUM_CH-1:0][15:0]  chan;
    logic [asr_pkg::NUM_SETUP-1:0][15:0] cfg;
    logic [asr_pkg::NUM_SETUP-1:0][23:0] flt;
    logic [6:0]                        onesCnt;
    logic                              busyS1;
    logic                              busyS2;
  } asr_regs_t;

  typedef struct packed {
    asr_ser_t    st;
    logic [5:0]  cnt;
    logic [5:0]  dataBits;
    logic [5:0]  len;
    logic [5:0]  addr;
    logic        drop;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [7:0]  crc;
  } asr_ser_state_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } asr_sync_t;

  localparam asr_regs_t REGS_RST = '{
    ctrl:    asr_pkg::CTRL_RST,
    io:      asr_pkg::IO_RST,
    errEn:   asr_pkg::ERREN_RST,
    ignErr:  1'b0,
    chan:    {{(asr_pkg::NUM_CH-1){asr_pkg::CH_RST}}, asr_pkg::CH0_RST},
    cfg:     {asr_pkg::NUM_SETUP{asr_pkg::CFG_RST}},
    flt:     {asr_pkg::NUM_SETUP{asr_pkg::FLT_RST}},
    onesCnt: 7'h00,
    busyS1:  1'b0,
    busyS2:  1'b0
  };

  localparam asr_ser_state_t SER_RST = '{
    st: SER_CMD, cnt: 6'h00, dataBits: 6'h00, len: 6'h00, addr: 6'h00,
    drop: 1'b0, rx: 32'h0, tx: 32'h0, crc: 8'h00
  };

  asr_regs_t      r;
  asr_regs_t      next_r;
  asr_ser_state_t s;
  asr_ser_state_t next_s;
  asr_sync_t      y;
  asr_sync_t      next_y;
  logic           serRstN;
  logic           wipe;
  logic           wrStb;
  logic [23:0]    wrData;
  logic           ignSet;
  logic           errRdStb;
  logic           crcOn;
  logic           doutBit;
  logic [7:0]     cmd;
  logic [23:0]    rdVal;
  logic [5:0]     cmdBits;

  // Chip select high holds the serial state idle; registers are untouched
  assign serRstN  = rst_n & ~spi.csN;
  // The 64th consecutive one on the data input wipes the whole device
  assign wipe     = spi.mosi && (r.onesCnt == asr_pkg::RESET_ONES - 7'h01);
  assign crcOn    = r.errEn[asr_pkg::ERREN_CRC_BIT];
  assign cmd      = {s.rx[6:0], spi.mosi};
  assign cmdBits  = asr_pkg::reg_bits(cmd[5:0]);

  // Read value of the register named by the arriving command
  always_comb begin
    rdVal = 24'h000000;
    if (cmd[5:0] == asr_pkg::ADDR_CTRL) begin
      rdVal = {8'h00, r.ctrl};
    end else if (cmd[5:0] == asr_pkg::ADDR_IO) begin
      rdVal = r.io;
    end else if (cmd[5:0] == asr_pkg::ADDR_ID) begin
      rdVal = {16'h0000, asr_pkg::PART_CODE, asr_pkg::DIE_REV};
    end else if (cmd[5:0] == asr_pkg::ADDR_ERR) begin
      rdVal = 24'(r.ignErr) << asr_pkg::ERR_IGN_BIT;
    end else if (cmd[5:0] == asr_pkg::ADDR_ERREN) begin
      rdVal = r.errEn;
    end else if (cmd[5:0] >= asr_pkg::ADDR_CH0 && cmd[5:0] < asr_pkg::ADDR_CFG0) begin
      rdVal = {8'h00, r.chan[4'(cmd[5:0] - asr_pkg::ADDR_CH0)]};
    end else if (cmd[5:0] >= asr_pkg::ADDR_CFG0 && cmd[5:0] < asr_pkg::ADDR_FLT0) begin
      rdVal = {8'h00, r.cfg[3'(cmd[5:0] - asr_pkg::ADDR_CFG0)]};
    end else if (cmd[5:0] >= asr_pkg::ADDR_FLT0 && cmd[5:0] < 6'h29) begin
      rdVal = r.flt[3'(cmd[5:0] - asr_pkg::ADDR_FLT0)];
    end
  end

  // Serial sequencer: sample on the rising edge of the link clock
  always_comb begin
    next_s   = s;
    wrStb    = 1'b0;
    wrData   = 24'h000000;
    ignSet   = 1'b0;
    errRdStb = 1'b0;
    unique case (s.st)
      SER_CMD: begin
        next_s.rx  = {s.rx[30:0], spi.mosi};
        next_s.cnt = s.cnt + 6'h01;
        next_s.crc = asr_pkg::crc_step((s.cnt == 6'h00) ? 8'h00 : s.crc, spi.mosi);
        if (s.cnt == asr_pkg::CMD_BITS - 6'h01) begin
          next_s.cnt  = 6'h00;
          next_s.addr = cmd[5:0];
          next_s.drop = r.busyS2;
          if (!cmd[asr_pkg::CMD_EN_BIT]) begin
            ignSet = r.busyS2 && r.errEn[asr_pkg::ERREN_IGN_BIT];
            next_s.dataBits = cmdBits;
            if (cmd[asr_pkg::CMD_RD_BIT]) begin
              next_s.st  = SER_RD;
              next_s.len = cmdBits + (crcOn ? asr_pkg::CRC_BITS : 6'h00);
              next_s.tx  = {rdVal, 8'h00} << (6'd24 - cmdBits);
              errRdStb   = (cmd[5:0] == asr_pkg::ADDR_ERR);
            end else begin
              next_s.st  = SER_WR;
              next_s.len = cmdBits;
            end
          end
        end
      end
      SER_WR: begin
        next_s.rx  = {s.rx[30:0], spi.mosi};
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == s.len - 6'h01) begin
          wrStb      = ~s.drop && (s.addr != asr_pkg::ADDR_ID);
          wrData     = next_s.rx[23:0];
          next_s.st  = SER_CMD;
          next_s.cnt = 6'h00;
        end
      end
      SER_RD: begin
        next_s.tx  = {s.tx[30:0], 1'b0};
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt < s.dataBits) begin
          next_s.crc = asr_pkg::crc_step(s.crc, s.tx[31]);
        end
        // Checksum byte follows the data when enabled
        if (crcOn && s.cnt == s.dataBits - 6'h01) begin
          next_s.tx = {next_s.crc, 24'h000000};
        end
        if (s.cnt == s.len - 6'h01) begin
          next_s.st  = SER_CMD;
          next_s.cnt = 6'h00;
        end
      end
    endcase
    if (wipe) begin
      next_s = SER_RST;
    end
  end

  // Register file update
  always_comb begin
    next_r        = r;
    next_r.busyS1 = convBusy;
    next_r.busyS2 = r.busyS1;
    if (!spi.mosi) begin
      next_r.onesCnt = 7'h00;
    end else if (r.onesCnt != asr_pkg::RESET_ONES) begin
      next_r.onesCnt = r.onesCnt + 7'h01;
    end
    if (wrStb) begin
      if (s.addr == asr_pkg::ADDR_CTRL) begin
        next_r.ctrl = wrData[15:0];
      end else if (s.addr == asr_pkg::ADDR_IO) begin
        next_r.io = wrData;
      end else if (s.addr == asr_pkg::ADDR_ERREN) begin
        next_r.errEn = wrData;
      end else if (s.addr >= asr_pkg::ADDR_CH0 && s.addr < asr_pkg::ADDR_CFG0) begin
        next_r.chan[4'(s.addr - asr_pkg::ADDR_CH0)] = wrData[15:0];
      end else if (s.addr >= asr_pkg::ADDR_CFG0 && s.addr < asr_pkg::ADDR_FLT0) begin
        next_r.cfg[3'(s.addr - asr_pkg::ADDR_CFG0)] = wrData[15:0];
      end else if (s.addr >= asr_pkg::ADDR_FLT0 && s.addr < 6'h29) begin
        next_r.flt[3'(s.addr - asr_pkg::ADDR_FLT0)] = wrData;
      end
    end
    // Reading the error register clears it; a new event in that edge wins
    if (errRdStb) begin
      next_r.ignErr = 1'b0;
    end
    if (ignSet) begin
      next_r.ignErr = 1'b1;
    end
    if (wipe) begin
      next_r         = REGS_RST;
      next_r.onesCnt = asr_pkg::RESET_ONES;
    end
  end

  // Register file: cleared only by power reset or the ones sequence
  always_ff @(posedge spi.sclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // Serial state: cleared by reset or by chip select going high
  always_ff @(posedge spi.sclk or negedge serRstN) begin
    if (!serRstN) begin
      s <= SER_RST;
    end else begin
      s <= next_s;
    end
  end

  // Output bit launched on the falling edge so the host samples it stable
  always_ff @(negedge spi.sclk or negedge serRstN) begin
    if (!serRstN) begin
      doutBit <= 1'b1;
    end else begin
      doutBit <= s.tx[31];
    end
  end

  assign spi.miso   = doutBit;
  assign spi.misoOe = ~spi.csN;

  // Link-domain levels carried into clk_sys through two flip-flops
  always_comb begin
    next_y.s1 = {r.io[asr_pkg::IO_GPOE_LSB +: 2] & r.io[asr_pkg::IO_GPIO_LSB +: 2],
                 r.io[asr_pkg::IO_GPOE_LSB +: 2],
                 r.ctrl[asr_pkg::CTRL_CLK_LSB +: 2] == asr_pkg::CLK_INT_OUT,
                 r.ctrl[asr_pkg::CTRL_CLK_LSB +: 2] == asr_pkg::CLK_EXT};
    next_y.s2 = y.s1;
  end

  // Sync flops freeze while the clock enable is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      y <= '0;
    end else if (ce) begin
      y <= next_y;
    end
  end

  assign gpioOut   = y.s2[5:4];
  assign gpioOe    = y.s2[3:2];
  assign intClkOut = y.s2[1];
  assign extClkSel = y.s2[0];
endmodule

// >>> rtl/asr_host.sv
/*
  Host end: runs transactions on the serial link from a request port,
  making the link clock from clk_sys by a divider.
  Assumes the user knows the data length of each register.
*/
`timescale 1ns/1ps
module asr_host #(
  parameter int HALF = asr_pkg::HOST_HALF,
  parameter int GAP  = asr_pkg::HOST_GAP
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Link
  asr_spi_if.host          spi,
  // Request
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqRead,
  input  wire logic        reqReset,
  input  wire logic [5:0]  reqAddr,
  input  wire logic [5:0]  reqBits,
  input  wire logic [23:0] reqData,
  input  wire logic        holdCs,
  // Answer
  output logic [31:0]      rdData,
  output logic             done
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW  = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP  = 4'b1000
  } asr_hst_t;

  typedef struct packed {
    asr_hst_t    st;
    logic [7:0]  div;
    logic [6:0]  bitIdx;
    logic [6:0]  total;
    logic        ones;
    logic [39:0] tx;
    logic [31:0] rx;
    logic        sclk;
    logic        csN;
    logic        mosi;
    logic        misoS1;
    logic        misoS2;
    logic [31:0] rdData;
    logic        done;
  } asr_host_state_t;

  asr_host_state_t h;
  asr_host_state_t next_h;

  assign reqReady = (h.st == H_IDLE);

  // Transaction sequencer
  always_comb begin
    next_h        = h;
    next_h.done   = 1'b0;
    next_h.misoS1 = spi.misoLine;
    next_h.misoS2 = h.misoS1;
    next_h.div    = h.div + 8'h01;
    unique case (h.st)
      H_IDLE: begin
        next_h.div  = 8'h00;
        next_h.sclk = 1'b1;
        next_h.csN  = ~holdCs;
        next_h.mosi = 1'b1;
        if (reqValid) begin
          // Command first: enable flag low, direction, address
          next_h.tx     = {1'b0, reqRead, reqAddr, {reqData, 8'h00} << (6'd24 - reqBits)};
          next_h.ones   = reqReset;
          next_h.total  = reqReset ? asr_pkg::RESET_ONES : 7'(asr_pkg::CMD_BITS + reqBits);
          next_h.bitIdx = 7'h00;
          next_h.rx     = 32'h0;
          next_h.csN    = 1'b0;
          next_h.st     = H_LOW;
        end
      end
      H_LOW: begin
        // Falling edge launches the next bit, most significant first
        next_h.sclk = 1'b0;
        next_h.mosi = h.ones | h.tx[39];
        if (h.div == 8'(HALF - 1)) begin
          next_h.div = 8'h00;
          next_h.st  = H_HIGH;
        end
      end
      H_HIGH: begin
        next_h.sclk = 1'b1;
        if (h.div == 8'(HALF - 1)) begin
          next_h.div    = 8'h00;
          next_h.tx     = {h.tx[38:0], 1'b0};
          next_h.bitIdx = h.bitIdx + 7'h01;
          if (h.bitIdx >= 7'(asr_pkg::CMD_BITS)) begin
            next_h.rx = {h.rx[30:0], h.misoS2};
          end
          next_h.st = (h.bitIdx == h.total - 7'h01) ? H_GAP : H_LOW;
        end
      end
      H_GAP: begin
        next_h.csN = ~holdCs;
        if (h.div == 8'(GAP - 1)) begin
          next_h.rdData = h.rx;
          next_h.done   = 1'b1;
          next_h.st     = H_IDLE;
        end
      end
      default: begin
        next_h.st = H_IDLE;
      end
    endcase
  end

  // All host state; the enable freezes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      h <= '{st: H_IDLE, sclk: 1'b1, csN: 1'b1, mosi: 1'b1, misoS1: 1'b1, misoS2: 1'b1, default: '0};
    end else if (ce) begin
      h <= next_h;
    end
  end

  assign spi.sclk = h.sclk;
  assign spi.csN  = h.csN;
  assign spi.mosi = h.mosi;
  assign rdData   = h.rdData;
  assign done     = h.done;
endmodule

// >>> bench/asr_link_props.sv
/*
  Link checker for the serial register-access front end.
  Assumes it sits beside the link interface and that the host half period is two system clocks.
*/
`timescale 1ns/1ps
module asr_link_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link signals
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic misoLine
);
  logic [9:0] edgeCount;
  logic       prevSclk;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Rising link edges per select window; a held select sums whole frames,
  // so the count is wide enough for sixteen long frames without wrapping
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edgeCount <= 10'h000;
      prevSclk  <= 1'b1;
    end else begin
      prevSclk <= sclk;
      if (csN) begin
        edgeCount <= 10'h000;
      end else if (sclk && !prevSclk) begin
        edgeCount <= edgeCount + 10'h001;
      end
    end
  end

  a_sclk_rests_high: assert property (csN |-> sclk)
    else $error("link clock low while deselected");
  a_cs_starts_low: assert property ($fell(csN) |-> sclk)
    else $error("frame opens with the link clock away from rest");
  a_sclk_half_period: assert property ($fell(sclk) |=> !sclk ##1 sclk)
    else $error("link clock low half has wrong length");
  a_mosi_holds_high: assert property ($rose(sclk) |=> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_on_fall: assert property ((!csN && !$past(csN) && $changed(miso)) |-> $fell(sclk))
    else $error("device data moved off the falling edge");
  a_oe_released: assert property (csN [*2] |-> !misoOe)
    else $error("device still drives while deselected");
  a_line_rests_high: assert property (csN |-> misoLine)
    else $error("serial output not at rest level");
  a_frame_whole_bytes: assert property ($rose(csN) |-> (edgeCount >= 10'h010 && edgeCount[2:0] == 3'h0))
    else $error("frame is not command plus whole bytes");

  c_reset_frame: cover property ($rose(csN) && edgeCount == 10'h040);
  c_read_data: cover property (misoOe && !miso);
  c_held_select: cover property ((!csN && sclk) [*4]);
endmodule

// >>> bench/testbench.sv
/*
  Self-checking bench: host end and device end joined by the link, register traffic
  compared with a behavioural register model. Assumes default host timing, 50 ns clock.
*/
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        rst_n;
  logic        ce;
  logic        reqValid;
  logic        reqReady;
  logic        reqRead;
  logic        reqReset;
  logic [5:0]  reqAddr;
  logic [5:0]  reqBits;
  logic [23:0] reqData;
  logic        holdCs;
  logic [31:0] rdData;
  logic        done;
  logic        convBusy;
  logic [1:0]  gpioOut;
  logic [1:0]  gpioOe;
  logic        intClkOut;
  logic        extClkSel;
  logic [23:0] d;
  logic [7:0]  idVal;
  int          num_errors;
  int          cmp_count;
  int          cycles;
  int          seed;
  int          mdl [int];

  asr_spi_if asr_spi_if_inst ();
  asr_device asr_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .spi(asr_spi_if_inst.dev),
    .convBusy(convBusy), .gpioOut(gpioOut), .gpioOe(gpioOe), .intClkOut(intClkOut), .extClkSel(extClkSel));
  asr_host asr_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .spi(asr_spi_if_inst.host),
    .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead), .reqReset(reqReset), .reqAddr(reqAddr),
    .reqBits(reqBits), .reqData(reqData), .holdCs(holdCs), .rdData(rdData), .done(done));
  asr_link_props asr_link_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(asr_spi_if_inst.sclk),
    .csN(asr_spi_if_inst.csN), .mosi(asr_spi_if_inst.mosi), .miso(asr_spi_if_inst.miso),
    .misoOe(asr_spi_if_inst.misoOe), .misoLine(asr_spi_if_inst.misoLine));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // A hang counts as a mismatch and still ends in the report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end

  task automatic results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Serial checksum written out bit by bit, command bits first
  function automatic logic [7:0] crc8(input logic [15:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? asr_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Register contents expected after any reset
  task automatic mdl_reset;
    mdl[asr_pkg::ADDR_CTRL]  = asr_pkg::CTRL_RST;
    mdl[asr_pkg::ADDR_IO]    = asr_pkg::IO_RST;
    mdl[asr_pkg::ADDR_ERR]   = 0;
    mdl[asr_pkg::ADDR_ERREN] = asr_pkg::ERREN_RST;
    mdl[asr_pkg::ADDR_CH0]   = asr_pkg::CH0_RST;
    mdl[10]                  = asr_pkg::CH_RST;
    mdl[asr_pkg::ADDR_CFG0]  = asr_pkg::CFG_RST;
    mdl[asr_pkg::ADDR_FLT0]  = asr_pkg::FLT_RST;
  endtask

  // One host transaction; the request is held for one clock, done is awaited under a bound
  task automatic xfer(input logic rd, input logic rs, input logic [5:0] a, input logic [5:0] nb,
                      input logic [23:0] wd);
    int n;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqRead  <= rd;
    reqReset <= rs;
    reqAddr  <= a;
    reqBits  <= nb;
    reqData  <= wd;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      results();
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [5:0] nb, input logic [31:0] exp);
    xfer(1'b1, 1'b0, a, nb, 24'h000000);
    check(rdData, exp);
    check(reqReady, 32'h00000001);
  endtask

  task automatic rd_all;
    foreach (mdl[k]) begin
      rd_chk(6'(k), asr_pkg::reg_bits(6'(k)), mdl[k]);
    end
  endtask

  initial begin
    rst_n    = 1'b0;
    ce       = 1'b1;
    reqValid = 1'b0;
    reqRead  = 1'b0;
    reqReset = 1'b0;
    reqAddr  = 6'h00;
    reqBits  = 6'h00;
    reqData  = 24'h000000;
    holdCs   = 1'b0;
    convBusy = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    cycles     = 0;
    seed       = 94;
    idVal      = {asr_pkg::PART_CODE, asr_pkg::DIE_REV};
    mdl_reset();
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Identity first, as a host does after power-up, then each modelled reset value
    rd_chk(asr_pkg::ADDR_ID, 6'h08, idVal);
    rd_all();
    // Each clock source selection, random mode and power fields
    for (int s = 0; s < 4; s++) begin
      d = 24'($random(seed)) & 24'h0000fc | 24'(s);
      xfer(1'b0, 1'b0, asr_pkg::ADDR_CTRL, 6'h10, d);
      mdl[asr_pkg::ADDR_CTRL] = d;
      repeat (3) @(posedge clk_sys);
      check(intClkOut, s == 1);
      check(extClkSel, s == 2);
      rd_chk(asr_pkg::ADDR_CTRL, 6'h10, mdl[asr_pkg::ADDR_CTRL]);
    end
    // Digital outputs back to back with select held low, as in three-wire use
    holdCs <= 1'b1;
    for (int s = 0; s < 16; s++) begin
      xfer(1'b0, 1'b0, asr_pkg::ADDR_IO, 6'h18, 24'(s));
      repeat (3) @(posedge clk_sys);
      check(gpioOut, s[1:0] & s[3:2]);
      check(gpioOe, s[3:2]);
    end
    mdl[asr_pkg::ADDR_IO] = 24'h00000f;
    holdCs <= 1'b0;
    rd_chk(asr_pkg::ADDR_IO, 6'h18, mdl[asr_pkg::ADDR_IO]);
    // Writes to the identity and command places are dropped
    xfer(1'b0, 1'b0, asr_pkg::ADDR_ID, 6'h08, 24'h0000a5);
    xfer(1'b0, 1'b0, asr_pkg::ADDR_CMD, 6'h08, 24'h0000ff);
    rd_chk(asr_pkg::ADDR_ID, 6'h08, idVal);
    rd_chk(asr_pkg::ADDR_CTRL, 6'h10, mdl[asr_pkg::ADDR_CTRL]);
    // A write during a busy period is ignored and flagged; reading the flag clears it
    convBusy <= 1'b1;
    repeat (2) @(posedge clk_sys);
    xfer(1'b0, 1'b0, asr_pkg::ADDR_CTRL, 6'h10, 24'h0000c1);
    convBusy <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd_chk(asr_pkg::ADDR_CTRL, 6'h10, mdl[asr_pkg::ADDR_CTRL]);
    rd_chk(asr_pkg::ADDR_ERR, 6'h18, 32'h00000040);
    rd_chk(asr_pkg::ADDR_ERR, 6'h18, 32'h00000000);
    // Checksum appended to a read
    xfer(1'b0, 1'b0, asr_pkg::ADDR_ERREN, 6'h18, 24'h040040);
    rd_chk(asr_pkg::ADDR_ID, 6'h10, {idVal, crc8({2'b01, asr_pkg::ADDR_ID, idVal})});
    xfer(1'b0, 1'b0, asr_pkg::ADDR_ERREN, 6'h18, 24'h000040);
    // Sixty-four ones restore every register
    xfer(1'b0, 1'b1, 6'h00, 6'h00, 24'h000000);
    mdl_reset();
    repeat (3) @(posedge clk_sys);
    check(gpioOe, 2'h0);
    rd_all();
    rd_chk(asr_pkg::ADDR_ID, 6'h08, idVal);
    results();
  end
endmodule
